// ===== ler_pkg.sv
package ler_pkg;

  // ----------------------------------------
  // register offsets (slave layout; hosts sit four bytes higher)
  // ----------------------------------------
  localparam logic [7:0] LER_ROUTE_OFF      = 8'h12;
  localparam logic [7:0] LER_BASE_EXT_OFF   = 8'h14;
  localparam logic [7:0] LER_LIMIT_EXT_OFF  = 8'h15;
  localparam logic [7:0] LER_BUS_NUM_OFF    = 8'h1A;
  localparam logic [7:0] LER_HOST_SHIFT     = 8'h04;

  // ----------------------------------------
  // error routing field positions
  // ----------------------------------------
  localparam int LER_PROT_FLOOD  = 0;
  localparam int LER_OVFL_FLOOD  = 1;
  localparam int LER_PROT_FATAL  = 2;
  localparam int LER_OVFL_FATAL  = 3;
  localparam int LER_EOC_FATAL   = 4;
  localparam int LER_RESP_FATAL  = 5;
  localparam int LER_CRC_FATAL   = 6;
  localparam int LER_SYS_FATAL   = 7;
  localparam int LER_CHAIN_FAIL  = 8;
  localparam int LER_RESP_ERR    = 9;
  localparam int LER_PROT_NFATAL = 10;
  localparam int LER_OVFL_NFATAL = 11;
  localparam int LER_EOC_NFATAL  = 12;
  localparam int LER_RESP_NFATAL = 13;
  localparam int LER_CRC_NFATAL  = 14;
  localparam int LER_SYS_NFATAL  = 15;

  // ----------------------------------------
  // writable masks and reset values
  // ----------------------------------------
  localparam logic [15:0] LER_FLOOD_MASK       = 16'h0003;
  localparam logic [15:0] LER_FATAL_MASK_SLV   = 16'h007C;
  localparam logic [15:0] LER_FATAL_MASK_HOST  = 16'h00FC;
  localparam logic [15:0] LER_NFATAL_MASK_SLV  = 16'h7C00;
  localparam logic [15:0] LER_NFATAL_MASK_HOST = 16'hFC00;
  localparam logic [15:0] LER_ROUTE_RST        = 16'h0000;
  localparam logic [7:0]  LER_EXT_RST          = 8'h00;
  localparam logic [7:0]  LER_BUS_RST          = 8'h00;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic prot;      // protocol error logged in a link error register
    logic ovfl;      // overflow error logged
    logic eoc;       // end-of-chain error logged
    logic inb_eoc;   // inbound end-of-chain flag of the host command register
    logic crc;       // any crc error flag of either link control register
    logic sys;       // system error detected, secondary status
  } ler_err_src_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ler_cfg_req_s;

endpackage

// ===== ler_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - overflow fatal enable routes logged overflow errors to the fatal interrupt
// - end-of-chain fatal enable routes logged or inbound chain-end errors to fatal
// - response fatal enable routes the response error status to fatal
// - crc fatal enable routes any crc error flag to fatal
// - system error fatal enable exists in hosts only; slaves read zero
// - without a fatal interrupt all fatal enables are hardwired zero
// - chain fail sets on sync flood detection, clears only by chain reset
// - response error sets on a received error, write-one clears, cold reset only
// - protocol nonfatal enable routes logged protocol errors to nonfatal
// - overflow nonfatal enable routes logged overflow errors to nonfatal
// - end-of-chain nonfatal enable routes chain-end errors to nonfatal
// - response nonfatal enable routes the response error status to nonfatal
// - crc nonfatal enable routes any crc error flag to nonfatal
// - system error nonfatal enable exists in hosts only; slaves read zero
// - without a nonfatal interrupt all nonfatal enables are hardwired zero
// - base extension widens non-prefetchable base to 40 bits, warm reset clears
// - limit extension widens non-prefetchable limit to 40 bits, warm reset clears
// - with 64-bit remapping present both extensions are reserved
// - hosts carry the extensions only when the extended register set is set
// - all bridges behind the primary link use these extension values
// - bus number captured from type 0 config writes, warm reset clears, not in hosts
// - non-hosts that originate messages or source ids keep the bus number
// - routing register at 12h or 16h, fatal and flood low, nonfatal high
// - protocol fatal enable routes logged protocol errors to fatal
// - flood enables flood the link on protocol or overflow errors; slaves also need the system error report enable
module ler_regs
  import ler_pkg::*;
#(
  parameter bit IS_HOST         = 1'b0,
  parameter bit HAS_FATAL_INT   = 1'b1,
  parameter bit HAS_NFATAL_INT  = 1'b1,
  parameter bit HAS_REMAP64     = 1'b0,
  parameter bit EXT_REG_SET     = 1'b1,
  parameter bit HAS_BUS_NUM     = 1'b1
) (
  // clock and resets
  input  wire logic         sys_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         warm_rst_in,
  input  wire logic         chain_rst_in,
  // configuration access
  input  wire ler_cfg_req_s cfg_req_in,
  output logic [7:0]        cfg_rdata_out,
  output logic              cfg_rvalid_out,
  // error sources
  input  wire ler_err_src_s err_src_in,
  input  wire logic         resp_err_in,
  input  wire logic         sync_flood_det_in,
  input  wire logic         system_error_report_enable_in,
  // type 0 configuration write capture
  input  wire logic         type0_wr_in,
  input  wire logic [7:0]   type0_bus_in,
  // results
  output logic              fatal_irq_out,
  output logic              nonfatal_irq_out,
  output logic              flood_req_out,
  output logic              chain_fail_out,
  output logic [7:0]        base_ext_out,
  output logic [7:0]        limit_ext_out,
  output logic [7:0]        bus_num_out
);

  // ----------------------------------------
  // map and presence
  // ----------------------------------------
  localparam logic [7:0] SHIFT     = IS_HOST ? LER_HOST_SHIFT : 8'h00;
  localparam logic [7:0] A_RT_LO   = LER_ROUTE_OFF + SHIFT;
  localparam logic [7:0] A_RT_HI   = LER_ROUTE_OFF + SHIFT + 8'h01;
  localparam logic [7:0] A_BASE    = LER_BASE_EXT_OFF + SHIFT;
  localparam logic [7:0] A_LIMIT   = LER_LIMIT_EXT_OFF + SHIFT;
  localparam bit         EXT_OK    = !IS_HOST || EXT_REG_SET;
  localparam bit         MEMX_OK   = EXT_OK && !HAS_REMAP64;
  localparam bit         BUS_OK    = !IS_HOST && HAS_BUS_NUM;
  localparam logic [15:0] FATAL_M  = !HAS_FATAL_INT ? 16'h0000 :
                                     (IS_HOST ? LER_FATAL_MASK_HOST : LER_FATAL_MASK_SLV);
  localparam logic [15:0] NFATAL_M = !HAS_NFATAL_INT ? 16'h0000 :
                                     (IS_HOST ? LER_NFATAL_MASK_HOST : LER_NFATAL_MASK_SLV);
  // status bits 8 and 9 are never stored here, so writes cannot set them
  localparam logic [15:0] WR_MASK  = EXT_OK ? (LER_FLOOD_MASK | FATAL_M | NFATAL_M) : 16'h0000;

  logic [15:0] route_ff;
  logic        resp_err_ff;
  logic        chain_fail_ff;
  logic [7:0]  base_ext_ff;
  logic [7:0]  limit_ext_ff;
  logic [7:0]  bus_num_ff;
  logic        fatal_ff;
  logic        nfatal_ff;
  logic        flood_ff;
  logic [7:0]  rdata_ff;
  logic        rvalid_ff;
  logic [15:0] route_view;
  logic        wr_lo;
  logic        wr_hi;
  logic        nxt_fatal;
  logic        nxt_nfatal;
  logic        nxt_flood;
  logic [7:0]  nxt_rdata;

  assign wr_lo = cfg_req_in.wr && (cfg_req_in.addr == A_RT_LO);
  assign wr_hi = cfg_req_in.wr && (cfg_req_in.addr == A_RT_HI);

  // ----------------------------------------
  // routing enables
  // ----------------------------------------
  // cold and warm reset both clear the enables
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      route_ff <= LER_ROUTE_RST;
    end else if (warm_rst_in) begin
      route_ff <= LER_ROUTE_RST;
    end else begin
      if (wr_lo) begin
        route_ff[7:0] <= cfg_req_in.wdata & WR_MASK[7:0];
      end
      if (wr_hi) begin
        route_ff[15:8] <= cfg_req_in.wdata & WR_MASK[15:8];
      end
    end
  end

  // ----------------------------------------
  // status bits
  // ----------------------------------------
  // warm reset deliberately leaves this flag alone; a new error beats a clear
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resp_err_ff <= 1'b0;
    end else if (EXT_OK && resp_err_in) begin
      resp_err_ff <= 1'b1;
    end else if (wr_hi && cfg_req_in.wdata[LER_RESP_ERR - 8]) begin
      resp_err_ff <= 1'b0;
    end
  end

  // only a reset of the failed chain clears it; a flood seen meanwhile wins
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chain_fail_ff <= 1'b0;
    end else if (EXT_OK && sync_flood_det_in) begin
      chain_fail_ff <= 1'b1;
    end else if (chain_rst_in) begin
      chain_fail_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // memory extensions and bus number
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      base_ext_ff  <= LER_EXT_RST;
      limit_ext_ff <= LER_EXT_RST;
    end else if (warm_rst_in) begin
      base_ext_ff  <= LER_EXT_RST;
      limit_ext_ff <= LER_EXT_RST;
    end else if (MEMX_OK && cfg_req_in.wr) begin
      if (cfg_req_in.addr == A_BASE) begin
        base_ext_ff <= cfg_req_in.wdata;
      end
      if (cfg_req_in.addr == A_LIMIT) begin
        limit_ext_ff <= cfg_req_in.wdata;
      end
    end
  end

  // read-only to software: only the link side's type 0 writes load it
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_num_ff <= LER_BUS_RST;
    end else if (warm_rst_in) begin
      bus_num_ff <= LER_BUS_RST;
    end else if (BUS_OK && type0_wr_in) begin
      bus_num_ff <= type0_bus_in;
    end
  end

  // ----------------------------------------
  // interrupt and flood requests
  // ----------------------------------------
  always_comb begin
    nxt_fatal =
      (route_ff[LER_PROT_FATAL] && err_src_in.prot) ||
      (route_ff[LER_OVFL_FATAL] && err_src_in.ovfl) ||
      (route_ff[LER_EOC_FATAL]  && (err_src_in.eoc || err_src_in.inb_eoc)) ||
      (route_ff[LER_RESP_FATAL] && resp_err_ff) ||
      (route_ff[LER_CRC_FATAL]  && err_src_in.crc) ||
      (route_ff[LER_SYS_FATAL]  && err_src_in.sys);
    nxt_nfatal =
      (route_ff[LER_PROT_NFATAL] && err_src_in.prot) ||
      (route_ff[LER_OVFL_NFATAL] && err_src_in.ovfl) ||
      (route_ff[LER_EOC_NFATAL]  && (err_src_in.eoc || err_src_in.inb_eoc)) ||
      (route_ff[LER_RESP_NFATAL] && resp_err_ff) ||
      (route_ff[LER_CRC_NFATAL]  && err_src_in.crc) ||
      (route_ff[LER_SYS_NFATAL]  && err_src_in.sys);
    // hosts flood regardless of the report enable
    nxt_flood = (IS_HOST || system_error_report_enable_in) &&
                ((route_ff[LER_PROT_FLOOD] && err_src_in.prot) ||
                 (route_ff[LER_OVFL_FLOOD] && err_src_in.ovfl));
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fatal_ff  <= 1'b0;
      nfatal_ff <= 1'b0;
      flood_ff  <= 1'b0;
    end else begin
      fatal_ff  <= nxt_fatal;
      nfatal_ff <= nxt_nfatal;
      flood_ff  <= nxt_flood;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    route_view                 = route_ff;
    route_view[LER_CHAIN_FAIL] = chain_fail_ff;
    route_view[LER_RESP_ERR]   = resp_err_ff;
    nxt_rdata                  = 8'h00;
    if (EXT_OK && cfg_req_in.addr == A_RT_LO) begin
      nxt_rdata = route_view[7:0];
    end else if (EXT_OK && cfg_req_in.addr == A_RT_HI) begin
      nxt_rdata = route_view[15:8];
    end else if (MEMX_OK && cfg_req_in.addr == A_BASE) begin
      nxt_rdata = base_ext_ff;
    end else if (MEMX_OK && cfg_req_in.addr == A_LIMIT) begin
      nxt_rdata = limit_ext_ff;
    end else if (BUS_OK && cfg_req_in.addr == LER_BUS_NUM_OFF) begin
      nxt_rdata = bus_num_ff;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= cfg_req_in.rd;
      if (cfg_req_in.rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // extensions are shared with every bridge header behind the primary link
  assign base_ext_out     = base_ext_ff;
  assign limit_ext_out    = limit_ext_ff;
  assign bus_num_out      = bus_num_ff;
  assign chain_fail_out   = chain_fail_ff;
  assign fatal_irq_out    = fatal_ff;
  assign nonfatal_irq_out = nfatal_ff;
  assign flood_req_out    = flood_ff;
  assign cfg_rdata_out    = rdata_ff;
  assign cfg_rvalid_out   = rvalid_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_lo_write(int b);
    !warm_rst_in && wr_lo && cfg_req_in.wdata[b];
  endsequence

  a_ovfl_fatal_route: assert property (route_ff[LER_OVFL_FATAL] && err_src_in.ovfl
    |=> fatal_irq_out) else $error("overflow not routed to fatal");
  a_eoc_fatal_route: assert property (route_ff[LER_EOC_FATAL] && err_src_in.inb_eoc
    |=> fatal_irq_out) else $error("inbound chain end not routed to fatal");
  a_resp_fatal_route: assert property (route_ff[LER_RESP_FATAL] && resp_err_ff
    |=> fatal_irq_out) else $error("response error not routed to fatal");
  a_crc_fatal_route: assert property (route_ff[LER_CRC_FATAL] && err_src_in.crc
    |=> fatal_irq_out) else $error("crc not routed to fatal");
  a_sys_fatal_slave: assert property (!IS_HOST |-> !route_ff[LER_SYS_FATAL]
    && !route_ff[LER_SYS_NFATAL]) else $error("host-only enable set in slave");
  a_fatal_hardwire: assert property (!HAS_FATAL_INT |-> (route_ff[7:2] == 6'h00)
    && !fatal_irq_out) else $error("fatal enable not hardwired");
  a_chain_fail_hold: assert property (chain_fail_ff && !chain_rst_in
    |=> chain_fail_ff) else $error("chain fail dropped without chain reset");
  a_resp_err_sets: assert property (EXT_OK && resp_err_in
    |=> resp_err_ff ##1 (resp_err_ff || $past(wr_hi)))
    else $error("response error not held");
  a_resp_err_warm: assert property (resp_err_ff && warm_rst_in && !wr_hi
    |=> resp_err_ff) else $error("warm reset cleared response error");
  a_prot_nfatal_route: assert property (route_ff[LER_PROT_NFATAL] && err_src_in.prot
    |=> nonfatal_irq_out) else $error("protocol not routed to nonfatal");
  a_ovfl_nfatal_route: assert property (route_ff[LER_OVFL_NFATAL] && err_src_in.ovfl
    |=> nonfatal_irq_out) else $error("overflow not routed to nonfatal");
  a_eoc_nfatal_route: assert property (route_ff[LER_EOC_NFATAL] && err_src_in.eoc
    |=> nonfatal_irq_out) else $error("chain end not routed to nonfatal");
  a_resp_nfatal_route: assert property (route_ff[LER_RESP_NFATAL] && resp_err_ff
    |=> nonfatal_irq_out) else $error("response error not routed to nonfatal");
  a_crc_nfatal_route: assert property (route_ff[LER_CRC_NFATAL] && err_src_in.crc
    |=> nonfatal_irq_out) else $error("crc not routed to nonfatal");
  a_nfatal_hardwire: assert property (!HAS_NFATAL_INT |-> (route_ff[15:10] == 6'h00)
    && !nonfatal_irq_out) else $error("nonfatal enable not hardwired");
  a_base_ext_write: assert property (MEMX_OK && !warm_rst_in && cfg_req_in.wr
    && cfg_req_in.addr == A_BASE |=> base_ext_out == $past(cfg_req_in.wdata))
    else $error("base extension not written");
  a_ext_warm_clear: assert property (warm_rst_in |=> base_ext_out == LER_EXT_RST
    && limit_ext_out == LER_EXT_RST) else $error("extension survived warm reset");
  a_ext_reserved: assert property (!MEMX_OK |-> base_ext_ff == LER_EXT_RST
    && limit_ext_ff == LER_EXT_RST) else $error("reserved extension changed");
  a_bus_capture: assert property (BUS_OK && !warm_rst_in && type0_wr_in
    |=> bus_num_out == $past(type0_bus_in)) else $error("bus number not captured");
  a_prot_fatal_route: assert property (s_lo_write(LER_PROT_FATAL) ##1 err_src_in.prot
    && !warm_rst_in |=> fatal_irq_out == HAS_FATAL_INT)
    else $error("protocol fatal route wrong");
  a_flood_route: assert property (route_ff[LER_OVFL_FLOOD] && err_src_in.ovfl
    && system_error_report_enable_in |=> flood_req_out) else $error("no flood");
  a_fatal_only_cause: assert property (fatal_irq_out |-> $past(nxt_fatal))
    else $error("fatal without cause");
  a_warm_clears_route: assert property (warm_rst_in |=> route_ff == LER_ROUTE_RST
    ##1 (route_ff & ~WR_MASK) == 16'h0000) else $error("routing not cleared");

endmodule

`default_nettype wire

// ===== link_error_routing_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module link_error_routing_regs_bench;
  import ler_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  localparam logic [7:0] ROUTE_HI = LER_ROUTE_OFF + 8'h01;
  logic         sys_clk_in        = 1'b0;
  logic         rst_n_in          = 1'b0;
  logic         warm_rst_in       = 1'b0;
  logic         chain_rst_in      = 1'b0;
  ler_cfg_req_s cfg_req_in        = '0;
  ler_err_src_s err_src_in        = '0;
  logic         resp_err_in       = 1'b0;
  logic         sync_flood_det_in = 1'b0;
  logic         report_en         = 1'b0;
  logic         type0_wr_in       = 1'b0;
  logic [7:0]   type0_bus_in      = 8'h00;
  logic [7:0]   rdata;
  logic [7:0]   base_ext;
  logic [7:0]   limit_ext;
  logic [7:0]   bus_num;
  logic         rvalid;
  logic         fatal;
  logic         nfatal;
  logic         flood;
  logic         chain_fail;
  logic [7:0]   h_rdata;
  logic [7:0]   h_base;
  logic [7:0]   h_bus;
  logic         h_fatal;
  logic         h_nfatal;
  logic         h_flood;
  int           err_count = 0;
  int           cmp_count = 0;
  int           cycles    = 0;

  ler_regs dut (
    .sys_clk_in                    (sys_clk_in),
    .rst_n_in                      (rst_n_in),
    .warm_rst_in                   (warm_rst_in),
    .chain_rst_in                  (chain_rst_in),
    .cfg_req_in                    (cfg_req_in),
    .cfg_rdata_out                 (rdata),
    .cfg_rvalid_out                (rvalid),
    .err_src_in                    (err_src_in),
    .resp_err_in                   (resp_err_in),
    .sync_flood_det_in             (sync_flood_det_in),
    .system_error_report_enable_in (report_en),
    .type0_wr_in                   (type0_wr_in),
    .type0_bus_in                  (type0_bus_in),
    .fatal_irq_out                 (fatal),
    .nonfatal_irq_out              (nfatal),
    .flood_req_out                 (flood),
    .chain_fail_out                (chain_fail),
    .base_ext_out                  (base_ext),
    .limit_ext_out                 (limit_ext),
    .bus_num_out                   (bus_num)
  );

  // host copy: shifted map, no fatal interrupt, 64-bit remapping present
  ler_regs #(
    .IS_HOST       (1'b1),
    .HAS_FATAL_INT (1'b0),
    .HAS_REMAP64   (1'b1)
  ) dut_host (
    .sys_clk_in                    (sys_clk_in),
    .rst_n_in                      (rst_n_in),
    .warm_rst_in                   (warm_rst_in),
    .chain_rst_in                  (chain_rst_in),
    .cfg_req_in                    (cfg_req_in),
    .cfg_rdata_out                 (h_rdata),
    .cfg_rvalid_out                (),
    .err_src_in                    (err_src_in),
    .resp_err_in                   (resp_err_in),
    .sync_flood_det_in             (sync_flood_det_in),
    .system_error_report_enable_in (report_en),
    .type0_wr_in                   (type0_wr_in),
    .type0_bus_in                  (type0_bus_in),
    .fatal_irq_out                 (h_fatal),
    .nonfatal_irq_out              (h_nfatal),
    .flood_req_out                 (h_flood),
    .chain_fail_out                (),
    .base_ext_out                  (h_base),
    .limit_ext_out                 (),
    .bus_num_out                   (h_bus)
  );

  initial begin
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // strobe is dropped a full cycle before the next access may raise it again
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_req_in.wr    = 1'b1;
    cfg_req_in.addr  = a;
    cfg_req_in.wdata = d;
    step(1);
    cfg_req_in.wr = 1'b0;
    step(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cfg_req_in.rd   = 1'b1;
    cfg_req_in.addr = a;
    step(1);
    cfg_req_in.rd = 1'b0;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp);
    step(1);
  endtask

  // exp holds fatal, nonfatal, flood one edge after the sources are applied
  task automatic route(input logic [15:0] en, input logic [5:0] s, input logic [2:0] exp);
    wr(LER_ROUTE_OFF, en[7:0]);
    wr(ROUTE_HI, en[15:8]);
    err_src_in = ler_err_src_s'(s);
    step(1);
    check({5'h00, fatal, nfatal, flood}, {5'h00, exp});
    err_src_in = '0;
  endtask

  task automatic warm();
    warm_rst_in = 1'b1;
    step(1);
    warm_rst_in = 1'b0;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // a hang is cut well past the fewer than two hundred cycles the sequence needs
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      complete_run();
    end
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    int          fb [6];
    logic [5:0]  sv [6];
    logic [15:0] en;
    logic [5:0]  neg;
    logic        e;
    fb = '{2, 3, 4, 4, 6, 7};
    sv = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
    step(3);
    rst_n_in = 1'b1;
    rd(LER_ROUTE_OFF, 8'h00);
    rd(ROUTE_HI, 8'h00);
    rd(LER_BASE_EXT_OFF, 8'h00);
    rd(LER_LIMIT_EXT_OFF, 8'h00);
    rd(LER_BUS_NUM_OFF, 8'h00);
    rd(8'h20, 8'h00);
    rd(LER_ROUTE_OFF + LER_HOST_SHIFT, 8'h00);
    // host: fatal enables hardwired, remap makes the extensions reserved
    wr(LER_ROUTE_OFF + LER_HOST_SHIFT, 8'hFF);
    wr(ROUTE_HI + LER_HOST_SHIFT, 8'hFF);
    wr(LER_BASE_EXT_OFF + LER_HOST_SHIFT, 8'hA5);
    rd(LER_ROUTE_OFF + LER_HOST_SHIFT, 8'h00);
    check(h_rdata, 8'h03);
    rd(ROUTE_HI + LER_HOST_SHIFT, 8'h00);
    check(h_rdata, 8'hFC);
    rd(LER_BASE_EXT_OFF + LER_HOST_SHIFT, 8'h00);
    check(h_rdata, 8'h00);
    check(h_base, 8'h00);
    // hosts flood with the report enable still low
    err_src_in = ler_err_src_s'(6'h21);
    step(1);
    check({5'h00, h_fatal, h_nfatal, h_flood}, 8'h03);
    err_src_in = '0;
    wr(LER_ROUTE_OFF, 8'hFF);
    wr(ROUTE_HI, 8'hFF);
    rd(LER_ROUTE_OFF, 8'h7F);
    rd(ROUTE_HI, 8'h7C);
    // protocol error standing in the cycle right after the enable write
    err_src_in = ler_err_src_s'(6'h20);
    wr(LER_ROUTE_OFF, 8'h04);
    check({6'h00, fatal, nfatal}, 8'h03);
    err_src_in = '0;
    // each enable paired with its own source, then with every unrelated source
    for (int k = 0; k < 6; k++) begin
      en  = (16'h0001 << fb[k]) | (16'h0100 << fb[k]);
      e   = (k < 5);
      neg = ~sv[k] & ((fb[k] == 4) ? 6'h33 : 6'h3F);
      route(en, sv[k], {e, e, 1'b0});
      route(en, neg, 3'b000);
    end
    route(16'h0000, 6'h3F, 3'b000);
    route(16'h0003, 6'h20, 3'b000);
    report_en = 1'b1;
    route(16'h0003, 6'h20, 3'b001);
    route(16'h0003, 6'h10, 3'b001);
    route(16'h0001, 6'h10, 3'b000);
    route(16'h2020, 6'h00, 3'b000);
    resp_err_in = 1'b1;
    step(1);
    resp_err_in = 1'b0;
    route(16'h2020, 6'h00, 3'b110);
    rd(ROUTE_HI, 8'h22);
    warm();
    rd(LER_ROUTE_OFF, 8'h00);
    rd(ROUTE_HI, 8'h02);
    wr(ROUTE_HI, 8'h02);
    rd(ROUTE_HI, 8'h00);
    sync_flood_det_in = 1'b1;
    step(1);
    sync_flood_det_in = 1'b0;
    rd(ROUTE_HI, 8'h01);
    check({7'h00, chain_fail}, 8'h01);
    warm();
    wr(ROUTE_HI, 8'h01);
    rd(ROUTE_HI, 8'h01);
    chain_rst_in = 1'b1;
    step(1);
    chain_rst_in = 1'b0;
    rd(ROUTE_HI, 8'h00);
    wr(LER_BASE_EXT_OFF, 8'hA5);
    wr(LER_LIMIT_EXT_OFF, 8'h5A);
    rd(LER_BASE_EXT_OFF, 8'hA5);
    rd(LER_LIMIT_EXT_OFF, 8'h5A);
    check(base_ext, 8'hA5);
    check(limit_ext, 8'h5A);
    type0_bus_in = 8'h3C;
    type0_wr_in  = 1'b1;
    step(1);
    type0_wr_in = 1'b0;
    rd(LER_BUS_NUM_OFF, 8'h3C);
    wr(LER_BUS_NUM_OFF, 8'hFF);
    rd(LER_BUS_NUM_OFF, 8'h3C);
    check(bus_num, 8'h3C);
    check(h_bus, 8'h00);
    warm();
    rd(LER_BASE_EXT_OFF, 8'h00);
    rd(LER_LIMIT_EXT_OFF, 8'h00);
    rd(LER_BUS_NUM_OFF, 8'h00);
    resp_err_in = 1'b1;
    step(1);
    resp_err_in = 1'b0;
    rst_n_in    = 1'b0;
    step(1);
    rst_n_in = 1'b1;
    rd(ROUTE_HI, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
